// [core/fcwp_map.vh]
// Constants for the fast channel word packer
`ifndef FCWP_MAP_VH
`define FCWP_MAP_VH
`define FCWP_SLICE_W      12
`define FCWP_WORD_W       60
`define FCWP_SLICES       3'h5
`define FCWP_CNT_RST      3'h0
`define FCWP_ADDR_W       18
`define FCWP_BUF_LEN_RST  18'h01000
`define FCWP_BLOCK_BIT    17
`define FCWP_EXIT_CODE    9'h00b
`endif

// [core/fcwp_out_ranks.v]
// Three-rank outbound slice pipeline for the fast channel
`timescale 1ns/1ps
module fcwp_out_ranks
#(
  parameter W = 12
)
(
  // Clock and control
  input  wire         ref_clk,
  input  wire         sys_rst,
  input  wire         clk_en,
  input  wire         flush,
  // Load from the output control
  input  wire         load,
  input  wire [W-1:0] load_data,
  // Resume from the unit, taken straight off the pin by the caller, no retiming
  input  wire         unit_resume,
  // Status and data
  output wire         ranks_full,
  output wire         rank_c_valid,
  output reg  [W-1:0] rank_c
);
  reg [W-1:0] rank_a;
  reg [W-1:0] rank_b;
  reg         va;
  reg         vb;
  reg         vc;

  // An empty rank pulls the slice in front of it, one rank per clock
  wire take_c = vc ? unit_resume : 1'b1;
  wire mv_bc  = vb && take_c;
  wire take_b = !vb || mv_bc;
  wire mv_ab  = va && take_b;

  assign ranks_full   = va && vb && vc;
  assign rank_c_valid = vc;

  // --------------------------------------------------------------
  // Rank registers
  // --------------------------------------------------------------
  always @(posedge ref_clk)
  begin
    if (sys_rst || flush)
    begin
      rank_a <= {W{1'b0}};
      rank_b <= {W{1'b0}};
      rank_c <= {W{1'b0}};
      va     <= 1'b0;
      vb     <= 1'b0;
      vc     <= 1'b0;
    end
    else if (clk_en)
    begin
      // Third rank stands until the unit resumes (see RL16)
      if (mv_bc)
      begin
        rank_c <= rank_b;
        vc     <= 1'b1;
      end
      else if (vc && unit_resume)
      begin
        rank_c <= {W{1'b0}};
        vc     <= 1'b0;
      end
      if (mv_ab)
      begin
        rank_b <= rank_a;
        vb     <= 1'b1;
      end
      else if (mv_bc)
        vb <= 1'b0;
      // First rank loaded on each word pulse (see RL14)
      if (load)
      begin
        rank_a <= load_data;
        va     <= 1'b1;
      end
      else if (mv_ab)
        va <= 1'b0;
    end
  end
endmodule

// [core/fcwp_top.v]
// Fast channel word packer: inbound packing and outbound three-rank unpacking
// How it works
// (RL1) Exit with block bit keeps interrupt flags
// (RL2) Unit stops reading at record length
// (RL3) Inbound word and record pulses not synchronised
// (RL4) Input reset clears counter, loads start address
// (RL5) First slice lands in top bits
// (RL6) Static resume while assembling
// (RL7) Five slices: request, drop resume, hold off
// (RL8) Accept: advance address, clear request, resume
// (RL9) Memory accept delay may be anything
// (RL10) Input threshold and record interrupts as normal
// (RL11) Outbound resume direct; three 12-bit ranks
// (RL12) Output reset loads start, requests word
// (RL13) Word arrival: clear count, pulses, top slice
// (RL14) Forward record pulse; load rank, word pulse
// (RL15) Word pulse suppressed during lockout
// (RL16) One rank per clock; C holds until resume
// (RL17) Internal resume sends next slice
// (RL18) Each further slice advances output address; the code advances it only after the fifth slice of a word
// (RL19) Full ranks withhold internal resume
// (RL20) After fifth slice request next word
// (RL21) Ranks drain, then halt until word
// (RL22) Unit resumes per slice; data held
// (RL23) Output threshold interrupts as normal
// (RL24) Interrupt at each half buffer
// (RL25) Lockout until exchange exit
// (RL26) Record pulse interrupts, zero-fills word
// (RL27) Reset clears ranks, counters, requests, pulses
`timescale 1ns/1ps
`include "fcwp_map.vh"
module fcwp_top
#(
  parameter AW = `FCWP_ADDR_W,
  parameter SW = `FCWP_SLICE_W,
  parameter WW = `FCWP_WORD_W
)
(
  // Clock, reset, enable
  input  wire          ref_clk,
  input  wire          sys_rst,
  input  wire          clk_en,
  // Buffer configuration
  input  wire [AW-1:0] in_buf_start,
  input  wire [AW-1:0] in_buf_len,
  input  wire [AW-1:0] out_buf_start,
  input  wire [AW-1:0] out_buf_len,
  // Reset instructions, one-cycle pulses
  input  wire          reset_in_chan,
  input  wire          reset_out_buf,
  // Exchange exit control
  input  wire          exchange_exit,
  input  wire [8:0]    exit_opcode,
  input  wire [AW-1:0] error_exit_address,
  // Inbound channel from the peripheral_processor_unit
  input  wire          ppu_in_word,
  input  wire          ppu_in_record,
  input  wire [SW-1:0] ppu_in_data,
  output wire          ppu_in_resume,
  // Outbound channel to the peripheral_processor_unit
  output reg           ppu_out_word,
  output reg           ppu_out_record,
  output wire [SW-1:0] ppu_out_data,
  input  wire          ppu_out_resume,
  // Central_memory write side
  output reg           cm_wr_req,
  output reg  [AW-1:0] cm_wr_addr,
  output reg  [WW-1:0] cm_wr_data,
  input  wire          cm_wr_accept,
  // Central_memory read side
  output reg           cm_rd_req,
  output reg  [AW-1:0] cm_rd_addr,
  input  wire          cm_rd_accept,
  input  wire          cm_rd_valid,
  input  wire [WW-1:0] cm_rd_data,
  // Interrupt requests and lockout status
  output reg           in_irq,
  output reg           out_irq,
  output reg           in_lockout,
  output reg           out_lockout
);

  // ------------------------------------------------------------------
  // Shared helpers
  // ------------------------------------------------------------------
  // True when the next address lands on a half-buffer boundary
  function at_half;
    input [AW-1:0] start;
    input [AW-1:0] len;
    input [AW-1:0] addr;
    reg   [AW-1:0] rel;
    begin
      rel     = addr - start;
      at_half = (rel == (len >> 1)) || (rel == len);
    end
  endfunction

  // Wraps the buffer address back to start for circular use
  function [AW-1:0] next_addr;
    input [AW-1:0] start;
    input [AW-1:0] len;
    input [AW-1:0] addr;
    begin
      if (addr + {{(AW-1){1'b0}}, 1'b1} - start >= len)
        next_addr = start;
      else
        next_addr = addr + {{(AW-1){1'b0}}, 1'b1};
    end
  endfunction

  // An exit only releases lockout when the block bit is clear
  wire exit_release = exchange_exit && (exit_opcode == `FCWP_EXIT_CODE) &&
                      !error_exit_address[`FCWP_BLOCK_BIT]; // see RL1

  // ------------------------------------------------------------------
  // Inbound packing
  // ------------------------------------------------------------------
  reg [2:0]    asm_cnt;
  reg [AW-1:0] in_addr;
  reg          in_irq_pend;

  // Static resume: dropped while the memory request or lockout stands
  assign ppu_in_resume = !cm_wr_req && !in_lockout; // see RL6
  // Pulses are used straight from the pins, no retiming stages
  wire in_word_ok = ppu_in_word && ppu_in_resume;   // see RL3
  wire in_rec_ok  = ppu_in_record && !cm_wr_req;     // see RL3
  wire in_last    = in_word_ok && (asm_cnt == `FCWP_SLICES - 3'h1);
  // Half-buffer crossing on the store that is being accepted
  wire in_thresh  = cm_wr_req && cm_wr_accept &&
                    at_half(in_buf_start, in_buf_len, in_addr + {{(AW-1){1'b0}}, 1'b1});

  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      asm_cnt    <= `FCWP_CNT_RST;
      in_addr    <= {AW{1'b0}};
      cm_wr_req  <= 1'b0;
      cm_wr_addr <= {AW{1'b0}};
      cm_wr_data <= {WW{1'b0}};
      in_irq     <= 1'b0;
      in_irq_pend <= 1'b0;
      in_lockout <= 1'b0;
    end
    else if (clk_en)
    begin
      in_irq <= 1'b0;
      if (reset_in_chan)
      begin
        asm_cnt    <= `FCWP_CNT_RST;       // see RL4
        in_addr    <= in_buf_start;        // see RL4
        cm_wr_req  <= 1'b0;
        cm_wr_data <= {WW{1'b0}};
      end
      else if (cm_wr_req)
      begin
        // Accept may take any number of cycles (see RL9)
        if (cm_wr_accept)
        begin
          cm_wr_req  <= 1'b0;                                          // see RL8
          in_addr    <= next_addr(in_buf_start, in_buf_len, in_addr); // see RL8
          cm_wr_data <= {WW{1'b0}};
        end
      end
      else if (in_word_ok)
      begin
        // Slices fill from the top down (see RL5)
        cm_wr_data <= cm_wr_data |
                      ({{(WW-SW){1'b0}}, ppu_in_data} << (SW * (`FCWP_SLICES - 3'h1 - asm_cnt)));
        if (in_last)
        begin
          cm_wr_req  <= 1'b1;              // see RL7
          cm_wr_addr <= in_addr;
          asm_cnt    <= `FCWP_CNT_RST;     // see RL7
        end
        else
          asm_cnt <= asm_cnt + 3'h1;
      end
      else if (in_rec_ok)
      begin
        // Record ends: store partial word, unused slices already zero (see RL26)
        if (asm_cnt != `FCWP_CNT_RST)
        begin
          cm_wr_req  <= 1'b1;
          cm_wr_addr <= in_addr;
          asm_cnt    <= `FCWP_CNT_RST;
        end
      end
      // Threshold and record interrupts, held back under lockout (see RL10)
      if (in_thresh || in_rec_ok || (in_irq_pend && exit_release))
      begin
        if (in_lockout && !exit_release)
          in_irq_pend <= 1'b1;             // see RL25
        else
        begin
          in_irq      <= 1'b1;             // see RL24
          in_irq_pend <= 1'b0;
          in_lockout  <= 1'b1;
        end
      end
      else if (exit_release)
        in_lockout <= 1'b0;                // see RL25
    end
  end

  // ------------------------------------------------------------------
  // Outbound unpacking
  // ------------------------------------------------------------------
  reg [WW-1:0] dis_reg;
  reg [2:0]    dis_cnt;
  reg          dis_busy;
  reg          int_resume;
  reg          first_pulse;
  reg          rd_pend;
  reg [AW-1:0] out_addr;
  reg          out_irq_pend;
  wire         ranks_full;
  wire         rank_c_valid;
  wire [SW-1:0] rank_c;

  // Resume from the unit taken straight off the pin (see RL11)
  wire unit_resume = ppu_out_resume;
  // Rank C holds each slice stable on the data lines until the unit resumes (see RL22)
  assign ppu_out_data = rank_c;

  // Next slice may go when ranks have room; the first slice of a word waits too,
  // otherwise a slow unit would lose the slice still standing in the first rank
  wire send_slice = dis_busy && (first_pulse || int_resume) &&
                    (!ranks_full || unit_resume); // see RL19
  // Lockout holds back loading of the first rank as well, so a slice is never loaded twice
  wire slice_go   = send_slice && !out_lockout;   // see RL15
  wire last_slice = slice_go && (dis_cnt == `FCWP_SLICES - 3'h1);
  wire out_thresh = last_slice && at_half(out_buf_start, out_buf_len,
                                          out_addr + {{(AW-1){1'b0}}, 1'b1});

  // Three ranks between the disassembly register and the unit (see RL11)
  fcwp_out_ranks #(.W(SW)) u_ranks
  (
    .ref_clk      (ref_clk),
    .sys_rst      (sys_rst),
    .clk_en       (clk_en),
    .flush        (reset_out_buf),
    .load         (slice_go),
    .load_data    (dis_reg[WW-1 -: SW]),
    .unit_resume  (unit_resume),
    .ranks_full   (ranks_full),
    .rank_c_valid (rank_c_valid),
    .rank_c       (rank_c)
  );

  // Output control sequencing
  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      dis_reg        <= {WW{1'b0}};
      dis_cnt        <= `FCWP_CNT_RST;     // see RL27
      dis_busy       <= 1'b0;
      int_resume     <= 1'b0;
      first_pulse    <= 1'b0;
      rd_pend        <= 1'b0;
      out_addr       <= {AW{1'b0}};
      cm_rd_req      <= 1'b0;              // see RL27
      cm_rd_addr     <= {AW{1'b0}};
      ppu_out_word   <= 1'b0;              // see RL27
      ppu_out_record <= 1'b0;
      out_irq        <= 1'b0;
      out_irq_pend   <= 1'b0;
      out_lockout    <= 1'b0;
    end
    else if (clk_en)
    begin
      ppu_out_word   <= 1'b0;
      ppu_out_record <= 1'b0;
      out_irq        <= 1'b0;
      first_pulse    <= 1'b0;
      if (reset_out_buf)
      begin
        out_addr   <= out_buf_start;       // see RL12
        cm_rd_req  <= 1'b1;                // see RL12
        cm_rd_addr <= out_buf_start;
        rd_pend    <= 1'b1;
        dis_busy   <= 1'b0;
        dis_cnt    <= `FCWP_CNT_RST;
        int_resume <= 1'b0;
      end
      else
      begin
        if (cm_rd_req && cm_rd_accept)
          cm_rd_req <= 1'b0;
        if (rd_pend && cm_rd_valid)
        begin
          dis_reg     <= cm_rd_data;        // see RL13
          dis_cnt     <= `FCWP_CNT_RST;     // see RL13
          dis_busy    <= 1'b1;
          rd_pend     <= 1'b0;
          first_pulse <= 1'b1;
          // Record pulse only at the start of a record
          ppu_out_record <= (out_addr == out_buf_start); // see RL14
        end
        else if (slice_go)
        begin
          ppu_out_word <= 1'b1;                          // see RL15
          dis_reg      <= dis_reg << SW;                 // see RL17
          int_resume   <= !ranks_full || unit_resume;   // see RL19
          if (last_slice)
          begin
            // Fifth slice sent: fetch the next word, ranks drain (see RL20)
            dis_busy   <= 1'b0;                          // see RL21
            out_addr   <= next_addr(out_buf_start, out_buf_len, out_addr); // see RL18
            cm_rd_req  <= 1'b1;
            cm_rd_addr <= next_addr(out_buf_start, out_buf_len, out_addr);
            rd_pend    <= 1'b1;
          end
          else
          begin
            // Address stays on this word until its fifth slice is out (see RL18)
            dis_cnt <= dis_cnt + 3'h1;
          end
        end
        else if (!first_pulse && !int_resume && dis_busy && unit_resume)
          int_resume <= 1'b1;                            // see RL19
        // A first slice held back by full ranks or lockout goes later
        if (first_pulse && !slice_go)
          int_resume <= 1'b1;                            // see RL17
      end
      // Output half-buffer interrupts with lockout (see RL23)
      if (out_thresh || (out_irq_pend && exit_release))
      begin
        if (out_lockout && !exit_release)
          out_irq_pend <= 1'b1;                          // see RL25
        else
        begin
          out_irq      <= 1'b1;                          // see RL24
          out_irq_pend <= 1'b0;
          out_lockout  <= 1'b1;
        end
      end
      else if (exit_release)
        out_lockout <= 1'b0;
    end
  end
endmodule

// [bench/fcwp_checker_assertions.sv]
// Port-level assertions for the fast channel word packer
`timescale 1ns/1ps
module fcwp_checker
#(
  parameter AW = 18,
  parameter SW = 12,
  parameter WW = 60
)
(
  // Clock and reset
  input wire          ref_clk,
  input wire          sys_rst,
  // Memory side
  input wire          cm_wr_req,
  input wire [AW-1:0] cm_wr_addr,
  input wire [WW-1:0] cm_wr_data,
  input wire          cm_wr_accept,
  input wire          cm_rd_req,
  input wire [AW-1:0] cm_rd_addr,
  input wire          cm_rd_accept,
  // Control and status
  input wire          reset_out_buf,
  input wire [AW-1:0] out_buf_start,
  input wire          exchange_exit,
  input wire [8:0]    exit_opcode,
  input wire [AW-1:0] error_exit_address,
  input wire          in_lockout,
  input wire          out_lockout,
  // Unit side
  input wire          ppu_in_resume,
  input wire          ppu_out_word,
  input wire          ppu_out_record,
  input wire [SW-1:0] ppu_out_data
);
  // ----------------------------------------
  // Checks, all in the one clock domain
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // Memory may stall for any time, so the request must stand untouched
  write_hold_a: assert property (cm_wr_req && !cm_wr_accept |=> cm_wr_req && $stable({cm_wr_addr, cm_wr_data}))
    else $error("write request changed before accept");
  resume_block_a: assert property (cm_wr_req |-> !ppu_in_resume)
    else $error("resume offered while write request open");
  accept_clear_a: assert property (cm_wr_req && cm_wr_accept |=> !cm_wr_req)
    else $error("write request not cleared by accept");
  read_start_a: assert property (reset_out_buf |=> cm_rd_req && cm_rd_addr == out_buf_start)
    else $error("output reset gave no read at buffer start");
  read_hold_a: assert property (cm_rd_req && !cm_rd_accept |=> cm_rd_req && $stable(cm_rd_addr))
    else $error("read request changed before accept");
  lockout_keep_a: assert property (exchange_exit && exit_opcode == 9'h00b && error_exit_address[17] && in_lockout
                                   |=> in_lockout)
    else $error("blocked exit released lockout");
  word_lockout_a: assert property (out_lockout && $past(out_lockout) |-> !ppu_out_word)
    else $error("word pulse during output lockout");
  reset_state_a: assert property (disable iff (1'b0) sys_rst |=> !cm_wr_req && !cm_rd_req && !ppu_out_word
                                  && !ppu_out_record && ppu_in_resume)
    else $error("outputs not idle after reset");
  // Main scenarios reached
  cover property (cm_wr_req && cm_wr_accept);
  cover property (ppu_out_record);
  cover property ($fell(ppu_in_resume));
endmodule

bind fcwp_top fcwp_checker #(.AW(AW), .SW(SW), .WW(WW)) fcwp_checker_inst (.*);

// [bench/fcwp_ppu_model.sv]
// Peripheral unit model: takes outbound slices and answers with resume pulses
`timescale 1ns/1ps
module fcwp_ppu_model
(
  // Clock, reset, pacing
  input wire        ref_clk,
  input wire        sys_rst,
  input wire [7:0]  hold_cycles,
  // Outbound channel
  input wire        ppu_out_word,
  input wire        ppu_out_record,
  input wire [11:0] ppu_out_data,
  output reg        ppu_out_resume,
  // What was taken
  output reg        got_valid,
  output reg [11:0] got_data,
  output reg [7:0]  rec_count
);
  reg [3:0] pending;
  reg [7:0] wait_cnt;
  // Count announced slices; a long hold lets all three ranks fill up
  always @(posedge ref_clk)
  begin
    got_valid <= 1'b0;
    ppu_out_resume <= 1'b0;
    if (sys_rst)
    begin
      pending <= 4'h0;
      wait_cnt <= 8'h00;
      rec_count <= 8'h00;
    end
    else
    begin
      if (ppu_out_record)
        rec_count <= rec_count + 8'h01;
      pending <= pending + {3'h0, ppu_out_word} - {3'h0, ppu_out_resume};
      if (pending != 4'h0 && !ppu_out_resume)
      begin
        if (wait_cnt >= hold_cycles)
        begin
          ppu_out_resume <= 1'b1;
          got_valid <= 1'b1;
          got_data <= ppu_out_data;
          wait_cnt <= 8'h00;
        end
        else
          wait_cnt <= wait_cnt + 8'h01;
      end
    end
  end
endmodule

// [bench/fcwp_tb.sv]
// Self-checking bench for the fast channel word packer
`timescale 1ns/1ps
module testbench;
  // Stimulus
  reg          ref_clk = 1'b0;
  reg          sys_rst = 1'b1;
  reg          reset_in_chan = 1'b0;
  reg          reset_out_buf = 1'b0;
  reg          exchange_exit = 1'b0;
  reg  [8:0]   exit_opcode = 9'h000;
  reg  [17:0]  error_exit_address = 18'h00000;
  reg          ppu_in_word = 1'b0;
  reg          ppu_in_record = 1'b0;
  reg  [11:0]  ppu_in_data = 12'h000;
  reg          cm_wr_accept = 1'b0;
  reg          cm_rd_accept = 1'b0;
  reg          cm_rd_valid = 1'b0;
  reg  [59:0]  cm_rd_data = 60'h0;
  reg  [7:0]   hold_cycles = 8'h14;
  // Observation
  wire         ppu_in_resume, ppu_out_word, ppu_out_record, ppu_out_resume, got_valid;
  wire [11:0]  ppu_out_data, got_data;
  wire [7:0]   rec_count;
  wire         cm_wr_req, cm_rd_req, in_irq, out_irq, in_lockout, out_lockout;
  wire [17:0]  cm_wr_addr, cm_rd_addr;
  wire [59:0]  cm_wr_data;
  logic [11:0] rx_q[$];
  integer      irq_seen = 0;
  integer      out_irq_seen = 0;
  integer      err_count = 0;
  integer      samples_checked = 0;
  integer      k;

  fcwp_top fcwp_top_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(1'b1), .in_buf_start(18'h00100),
    .in_buf_len(18'h00004), .out_buf_start(18'h00200), .out_buf_len(18'h00004), .reset_in_chan(reset_in_chan),
    .reset_out_buf(reset_out_buf), .exchange_exit(exchange_exit), .exit_opcode(exit_opcode),
    .error_exit_address(error_exit_address), .ppu_in_word(ppu_in_word), .ppu_in_record(ppu_in_record),
    .ppu_in_data(ppu_in_data), .ppu_in_resume(ppu_in_resume), .ppu_out_word(ppu_out_word),
    .ppu_out_record(ppu_out_record), .ppu_out_data(ppu_out_data), .ppu_out_resume(ppu_out_resume),
    .cm_wr_req(cm_wr_req), .cm_wr_addr(cm_wr_addr), .cm_wr_data(cm_wr_data), .cm_wr_accept(cm_wr_accept),
    .cm_rd_req(cm_rd_req), .cm_rd_addr(cm_rd_addr), .cm_rd_accept(cm_rd_accept), .cm_rd_valid(cm_rd_valid),
    .cm_rd_data(cm_rd_data), .in_irq(in_irq), .out_irq(out_irq), .in_lockout(in_lockout),
    .out_lockout(out_lockout));
  fcwp_ppu_model fcwp_ppu_model_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .hold_cycles(hold_cycles),
    .ppu_out_word(ppu_out_word), .ppu_out_record(ppu_out_record), .ppu_out_data(ppu_out_data),
    .ppu_out_resume(ppu_out_resume), .got_valid(got_valid), .got_data(got_data), .rec_count(rec_count));

  // ----------------------------------------
  // Clock, collectors and tasks
  // ----------------------------------------
  always #50 ref_clk = ~ref_clk;
  // Slices and interrupts are gathered in the background, as they arrive during memory cycles
  always @(posedge ref_clk)
  begin
    if (got_valid === 1'b1) rx_q.push_back(got_data);
    if (in_irq === 1'b1) irq_seen = irq_seen + 1;
    if (out_irq === 1'b1) out_irq_seen = out_irq_seen + 1;
  end
  task automatic tick;
  begin
    @(posedge ref_clk);
    #1;
  end
  endtask
  task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
  begin
    samples_checked = samples_checked + 1;
    if (seen !== exp)
    begin
      err_count = err_count + 1;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  end
  endtask
  // Word stays high between slices so back-to-back slices need no idle edge
  task automatic send_slice(input [11:0] d);
    integer i;
  begin
    for (i = 0; i < 500 && ppu_in_resume !== 1'b1; i = i + 1) tick;
    ppu_in_word = 1'b1;
    ppu_in_data = d;
    tick;
  end
  endtask
  task automatic idle_in;
  begin
    ppu_in_word = 1'b0;
    ppu_in_data = ~ppu_in_data;
  end
  endtask
  task automatic pulse_exit(input [17:0] eea);
  begin
    error_exit_address = eea;
    exit_opcode = 9'h00b;
    exchange_exit = 1'b1;
    tick;
    exchange_exit = 1'b0;
    repeat (3) tick;
  end
  endtask
  task automatic mem_write(input [17:0] a, input [59:0] d, input integer lag);
    integer i;
  begin
    for (i = 0; i < 500 && cm_wr_req !== 1'b1; i = i + 1) tick;
    check(cm_wr_addr, a, "write address");
    check(cm_wr_data, d, "write data");
    repeat (lag) tick;
    cm_wr_accept = 1'b1;
    tick;
    cm_wr_accept = 1'b0;
    tick;
  end
  endtask
  task automatic mem_read(input [17:0] a, input [59:0] d, input integer lag);
    integer i;
  begin
    for (i = 0; i < 500 && cm_rd_req !== 1'b1; i = i + 1) tick;
    check(cm_rd_addr, a, "read address");
    repeat (lag) tick;
    cm_rd_accept = 1'b1;
    tick;
    cm_rd_accept = 1'b0;
    tick;
    cm_rd_valid = 1'b1;
    cm_rd_data = d;
    tick;
    cm_rd_valid = 1'b0;
    cm_rd_data = ~d;
  end
  endtask
  task automatic final_report;
  begin
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  end
  endtask

  // ----------------------------------------
  // Test sequence and watchdog
  // ----------------------------------------
  initial
  begin
    repeat (10) tick;
    sys_rst = 1'b0;
    tick;
    check(ppu_in_resume, 1'b1, "resume after reset");
    reset_in_chan = 1'b1;
    tick;
    reset_in_chan = 1'b0;
    for (k = 1; k <= 5; k = k + 1) send_slice(k[11:0]);
    idle_in;
    tick;
    ppu_in_word = 1'b1; // Offered while the request is open, must be dropped
    ppu_in_data = 12'hfff;
    repeat (2) tick;
    idle_in;
    mem_write(18'h00100, 60'h001002003004005, 40);
    check(ppu_in_resume, 1'b1, "resume after accept");
    for (k = 1; k <= 5; k = k + 1) send_slice(12'h010 + k[11:0]);
    idle_in;
    mem_write(18'h00101, 60'h011012013014015, 2);
    repeat (5) tick;
    check(irq_seen, 1, "half buffer interrupt");
    check(in_lockout, 1'b1, "lockout after interrupt");
    pulse_exit(18'h20000);
    check(in_lockout, 1'b1, "blocked exit kept lockout");
    pulse_exit(18'h00000);
    check(in_lockout, 1'b0, "exit released lockout");
    send_slice(12'h021);
    send_slice(12'h022);
    idle_in;
    tick;
    ppu_in_record = 1'b1;
    tick;
    ppu_in_record = 1'b0;
    mem_write(18'h00102, 60'h021022000000000, 1);
    repeat (5) tick;
    check(irq_seen, 2, "record interrupt");
    $display("test inbound done");
    reset_out_buf = 1'b1;
    tick;
    reset_out_buf = 1'b0;
    mem_read(18'h00200, 60'h101102103104105, 3);
    hold_cycles = 8'h03;
    mem_read(18'h00201, 60'h201202203204205, 0);
    for (k = 0; k < 1000 && rx_q.size() < 10; k = k + 1) tick;
    check(rx_q.size(), 10, "slice count");
    check(out_irq_seen, 1, "output half buffer interrupt");
    check(out_lockout, 1'b1, "output lockout after interrupt");
    mem_read(18'h00202, 60'h301302303304305, 0);
    repeat (20) tick;
    check(rx_q.size(), 10, "no slice during output lockout");
    hold_cycles = 8'hff; // Unit stops reading for a while
    pulse_exit(18'h00000);
    repeat (20) tick;
    check(ppu_out_data, 12'h301, "third rank holds slice");
    check(rx_q.size(), 10, "stalled unit takes nothing");
    hold_cycles = 8'h03;
    for (k = 0; k < 1000 && rx_q.size() < 15; k = k + 1) tick;
    check(rx_q.size(), 15, "slice count after release");
    for (k = 0; k < 15; k = k + 1)
      check(rx_q[k], (k < 5) ? 12'h101 + k : (k < 10) ? 12'h1fc + k : 12'h2f7 + k, "slice order");
    check(rec_count, 8'h01, "record pulses");
    $display("test outbound done");
    final_report;
  end
  // A hung handshake ends the run through the same report
  initial
  begin
    repeat (5000) @(posedge ref_clk);
    err_count = err_count + 1;
    final_report;
  end
endmodule
